// [core/asrs_consts.vh]
// Constants for the audio stream receive statistics block
`ifndef ASRS_CONSTS_VH
`define ASRS_CONSTS_VH

// Geometry
`define ASRS_NUM_INPUTS 297
`define ASRS_IDX_W 9
`define ASRS_CNT_W 32
`define ASRS_LVL_W 8
`define ASRS_BUF_DEPTH 64
`define ASRS_TS_W 32

// Loss weights in 12-sample blocks, timestamp steps in samples
`define ASRS_LIVE_BLOCKS 1
`define ASRS_STD_BLOCKS 20
`define ASRS_LIVE_TS_STEP 12
`define ASRS_STD_TS_STEP 240

// Register offsets (byte addresses)
`define ASRS_REG_CTRL 8'h00
`define ASRS_REG_SEL 8'h04
`define ASRS_REG_NORMAL 8'h08
`define ASRS_REG_OVERRUN 8'h0C
`define ASRS_REG_RESUMED 8'h10
`define ASRS_REG_SEQDEF 8'h14
`define ASRS_REG_UNDERRUN 8'h18
`define ASRS_REG_LEVEL 8'h1C
`define ASRS_REG_IRQ_STAT 8'h20
`define ASRS_REG_IRQ_MASK 8'h24

// Control bits
`define ASRS_CTRL_CLEAR_BIT 0

// Interrupt status bit positions
`define ASRS_IRQ_OVERRUN 0
`define ASRS_IRQ_RESUMED 1
`define ASRS_IRQ_SEQDEF 2
`define ASRS_IRQ_UNDERRUN 3
`define ASRS_IRQ_W 4

`endif

// [core/asrs_sat_add.v]
// Saturating counter adder used by every statistics counter
`timescale 1ns/1ps
module asrs_sat_add #(
    parameter W = 32
) (
    input wire [W-1:0] val_i, // Current count
    input wire [W-1:0] inc_i, // Amount to add
    output wire [W-1:0] sum_o // Saturated sum
);
    wire [W:0] wide;

    // Carry out means the count would wrap, so pin it at all ones
    assign wide = {1'b0, val_i} + {1'b0, inc_i};
    assign sum_o = wide[W] ? {W{1'b1}} : wide[W-1:0];
endmodule // asrs_sat_add

// [core/asrs_stats.v]
// Per-input receive statistics, buffer level tracking and register port
// What this block does
// - Separate statistics per input, up to 297 inputs.
// - Normal counter counts only on-time, in-sequence packets.
// - Packet arriving with buffer full records an overrun.
// - After overrun the input resynchronizes to its nominal buffer position.
// - Overrun counter accumulates all overruns since stream connection.
// - Buffer draining empty is an interruption and resynchronizes the stream.
// - Resumed counter counts once per gap, at first packet after it.
// - Timestamp gap between consecutive packets increments sequence-defect counter.
// - Missed DSP read adds one per missed 12-sample block.
// - Lost live packet adds 1, lost standard packet adds 20.
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "asrs_consts.vh"
module asrs_stats #(
    parameter NUM_INPUTS = `ASRS_NUM_INPUTS,
    parameter IDX_W = `ASRS_IDX_W,
    parameter CNT_W = `ASRS_CNT_W,
    parameter LVL_W = `ASRS_LVL_W,
    parameter BUF_DEPTH = `ASRS_BUF_DEPTH,
    parameter TS_W = `ASRS_TS_W
) (
    input wire clk_i, // 20 MHz clock
    input wire reset_n_i, // Synchronous reset, active low
    input wire pkt_valid_i, // Packet arrival pulse
    input wire [IDX_W-1:0] pkt_input_i, // Input the packet belongs to
    input wire [TS_W-1:0] pkt_ts_i, // Packet timestamp in samples
    input wire pkt_live_i, // 1: live packet (1 block), 0: standard (20)
    input wire rd_valid_i, // DSP read-cycle pulse for one input
    input wire [IDX_W-1:0] rd_input_i, // Input the DSP reads
    input wire [7:0] addr_i, // Register byte address
    input wire [31:0] wdata_i, // Register write data
    input wire wr_i, // Register write strobe
    input wire rd_i, // Register read strobe
    output reg [31:0] rdata_o, // Read data, valid the cycle after rd_i
    output reg irq_o // Level interrupt
);
    // ========================================================
    // Storage
    // ========================================================
    reg [CNT_W-1:0] normal_reg [0:NUM_INPUTS-1];
    reg [CNT_W-1:0] overrun_reg [0:NUM_INPUTS-1];
    reg [CNT_W-1:0] resumed_reg [0:NUM_INPUTS-1];
    reg [CNT_W-1:0] seqdef_reg [0:NUM_INPUTS-1];
    reg [CNT_W-1:0] underrun_reg [0:NUM_INPUTS-1];
    reg [LVL_W-1:0] level_reg [0:NUM_INPUTS-1];
    reg [TS_W-1:0] last_ts_reg [0:NUM_INPUTS-1];
    reg [NUM_INPUTS-1:0] seen_reg; // A first packet has arrived
    reg [NUM_INPUTS-1:0] gap_reg; // Buffer ran empty, waiting to resume
    reg [NUM_INPUTS-1:0] lastlive_reg; // Size kind of latest packet
    reg [IDX_W-1:0] sel_reg;
    reg [LVL_W-1:0] nominal_reg;
    reg [`ASRS_IRQ_W-1:0] irq_stat_reg;
    reg [`ASRS_IRQ_W-1:0] irq_mask_reg;

    localparam [LVL_W-1:0] FULL_LVL = BUF_DEPTH[LVL_W-1:0];
    localparam HALF_DEPTH = BUF_DEPTH / 2;
    localparam [LVL_W-1:0] NOMINAL_RST = HALF_DEPTH[LVL_W-1:0];

    // Index is in range
    function in_range;
        input [IDX_W-1:0] idx;
        begin
            in_range = (idx < NUM_INPUTS);
        end
    endfunction

    // Loss weight by kind, in 12-sample blocks
    function [CNT_W-1:0] loss_weight;
        input live;
        begin
            loss_weight = live ? `ASRS_LIVE_BLOCKS : `ASRS_STD_BLOCKS;
        end
    endfunction

    // ========================================================
    // Per-packet evaluation for the addressed input
    // ========================================================
    wire pk_ok;
    wire rd_ok;
    wire [LVL_W-1:0] pk_lvl;
    wire [TS_W-1:0] ts_step;
    wire [TS_W-1:0] ts_expect;
    wire pk_full;
    wire pk_late;
    wire pk_gap;
    wire pk_seqdef;
    wire pk_normal;
    wire rd_empty;
    wire clear;
    wire same_input;

    assign pk_ok = pkt_valid_i & in_range(pkt_input_i);
    assign rd_ok = rd_valid_i & in_range(rd_input_i);
    assign pk_lvl = level_reg[pkt_input_i];
    assign ts_step = pkt_live_i ? `ASRS_LIVE_TS_STEP : `ASRS_STD_TS_STEP;
    assign ts_expect = last_ts_reg[pkt_input_i] + ts_step;
    assign pk_full = (pk_lvl >= FULL_LVL);
    assign pk_gap = gap_reg[pkt_input_i];
    assign pk_seqdef = seen_reg[pkt_input_i] & ~pk_gap & (pkt_ts_i != ts_expect)
        & ((pkt_ts_i - ts_expect) < {1'b0, {(TS_W-1){1'b1}}});
    // Timestamp behind expectation means a late or reordered packet
    assign pk_late = seen_reg[pkt_input_i] & ~pk_gap & (pkt_ts_i != ts_expect)
        & ~pk_seqdef;
    // Normal only if on time and in order
    assign pk_normal = ~pk_full & ~pk_late & ~pk_seqdef;
    assign rd_empty = (level_reg[rd_input_i] == {LVL_W{1'b0}});
    assign clear = wr_i & (addr_i == `ASRS_REG_CTRL) & wdata_i[`ASRS_CTRL_CLEAR_BIT];
    assign same_input = pk_ok & rd_ok & (pkt_input_i == rd_input_i);

    // ========================================================
    // Saturating sums for the counters touched this cycle
    // ========================================================
    wire [CNT_W-1:0] normal_sum;
    wire [CNT_W-1:0] overrun_sum;
    wire [CNT_W-1:0] resumed_sum;
    wire [CNT_W-1:0] seqdef_sum;
    wire [CNT_W-1:0] underrun_sum;

    asrs_sat_add #(.W(CNT_W)) u_add_normal (
        .val_i(normal_reg[pkt_input_i]),
        .inc_i({{(CNT_W-1){1'b0}}, 1'b1}),
        .sum_o(normal_sum)
    );
    asrs_sat_add #(.W(CNT_W)) u_add_overrun (
        .val_i(overrun_reg[pkt_input_i]),
        .inc_i({{(CNT_W-1){1'b0}}, 1'b1}),
        .sum_o(overrun_sum)
    );
    asrs_sat_add #(.W(CNT_W)) u_add_resumed (
        .val_i(resumed_reg[pkt_input_i]),
        .inc_i({{(CNT_W-1){1'b0}}, 1'b1}),
        .sum_o(resumed_sum)
    );
    asrs_sat_add #(.W(CNT_W)) u_add_seqdef (
        .val_i(seqdef_reg[pkt_input_i]),
        .inc_i({{(CNT_W-1){1'b0}}, 1'b1}),
        .sum_o(seqdef_sum)
    );
    asrs_sat_add #(.W(CNT_W)) u_add_underrun (
        .val_i(underrun_reg[rd_input_i]),
        .inc_i(loss_weight(lastlive_reg[rd_input_i])),
        .sum_o(underrun_sum)
    );

    // ========================================================
    // Per-input state, one slice per input
    // ========================================================
    // Per-input slices
    genvar g;
    generate
        for (g = 0; g < NUM_INPUTS; g = g + 1)
        begin : g_in
            wire pk_hit;
            wire rd_hit;
            assign pk_hit = pk_ok & (pkt_input_i == g);
            assign rd_hit = rd_ok & (rd_input_i == g);

            // Counters; clear applies to all inputs at once
            always @(posedge clk_i)
            begin
                if (!reset_n_i || clear)
                begin
                    normal_reg[g] <= {CNT_W{1'b0}};
                    overrun_reg[g] <= {CNT_W{1'b0}};
                    resumed_reg[g] <= {CNT_W{1'b0}};
                    seqdef_reg[g] <= {CNT_W{1'b0}};
                    underrun_reg[g] <= {CNT_W{1'b0}};
                end
                else
                begin
                    if (pk_hit && pk_normal)
                        normal_reg[g] <= normal_sum;
                    if (pk_hit && pk_full)
                        overrun_reg[g] <= overrun_sum;
                    if (pk_hit && pk_gap)
                        resumed_reg[g] <= resumed_sum;
                    if (pk_hit && pk_seqdef)
                        seqdef_reg[g] <= seqdef_sum;
                    if (rd_hit && rd_empty && !(pk_hit))
                        underrun_reg[g] <= underrun_sum;
                end
            end

            // Buffer level tracking; stream state is kept over a clear
            always @(posedge clk_i)
            begin
                if (!reset_n_i)
                begin
                    level_reg[g] <= {LVL_W{1'b0}};
                    last_ts_reg[g] <= {TS_W{1'b0}};
                    seen_reg[g] <= 1'b0;
                    gap_reg[g] <= 1'b1;
                    lastlive_reg[g] <= 1'b0;
                end
                else
                begin
                    if (pk_hit)
                    begin
                        last_ts_reg[g] <= pkt_ts_i;
                        seen_reg[g] <= 1'b1;
                        lastlive_reg[g] <= pkt_live_i;
                        gap_reg[g] <= 1'b0;
                        if (pk_full || pk_gap)
                            level_reg[g] <= nominal_reg;
                        else if (!rd_hit)
                            level_reg[g] <= level_reg[g] + 1'b1;
                    end
                    else if (rd_hit)
                    begin
                        if (!rd_empty)
                            level_reg[g] <= level_reg[g] - 1'b1;
                        if (level_reg[g] == {{(LVL_W-1){1'b0}}, 1'b1} || rd_empty)
                            gap_reg[g] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    // ========================================================
    // Interrupt status: set wins over write-one-to-clear
    // ========================================================
    wire [`ASRS_IRQ_W-1:0] irq_set;
    wire [`ASRS_IRQ_W-1:0] irq_clr;
    assign irq_set = {rd_ok & rd_empty & ~same_input, pk_ok & pk_seqdef,
        pk_ok & pk_gap, pk_ok & pk_full};
    assign irq_clr = (wr_i && addr_i == `ASRS_REG_IRQ_STAT) ?
        wdata_i[`ASRS_IRQ_W-1:0] : {`ASRS_IRQ_W{1'b0}};

    // Interrupt registers and output
    always @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            irq_stat_reg <= {`ASRS_IRQ_W{1'b0}};
            irq_o <= 1'b0;
        end
        else
        begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
            irq_o <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_mask_reg);
        end
    end

    // ========================================================
    // Register writes
    // ========================================================
    always @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            sel_reg <= {IDX_W{1'b0}};
            nominal_reg <= NOMINAL_RST;
            irq_mask_reg <= {`ASRS_IRQ_W{1'b0}};
        end
        else if (wr_i)
        begin
            case (addr_i)
                `ASRS_REG_SEL: sel_reg <= wdata_i[IDX_W-1:0];
                `ASRS_REG_LEVEL: nominal_reg <= wdata_i[LVL_W-1:0];
                `ASRS_REG_IRQ_MASK: irq_mask_reg <= wdata_i[`ASRS_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // ========================================================
    // Register reads: side-effect free, unmapped reads zero
    // ========================================================
    wire sel_ok;
    assign sel_ok = in_range(sel_reg);

    always @(posedge clk_i)
    begin
        if (!reset_n_i)
            rdata_o <= 32'h00000000;
        else if (rd_i)
        begin
            rdata_o <= 32'h00000000;
            case (addr_i)
                `ASRS_REG_SEL: rdata_o[IDX_W-1:0] <= sel_reg;
                `ASRS_REG_NORMAL: if (sel_ok) rdata_o[CNT_W-1:0] <= normal_reg[sel_reg];
                `ASRS_REG_OVERRUN: if (sel_ok) rdata_o[CNT_W-1:0] <= overrun_reg[sel_reg];
                `ASRS_REG_RESUMED: if (sel_ok) rdata_o[CNT_W-1:0] <= resumed_reg[sel_reg];
                `ASRS_REG_SEQDEF: if (sel_ok) rdata_o[CNT_W-1:0] <= seqdef_reg[sel_reg];
                `ASRS_REG_UNDERRUN: if (sel_ok) rdata_o[CNT_W-1:0] <= underrun_reg[sel_reg];
                `ASRS_REG_LEVEL: if (sel_ok) rdata_o <= {8'h00, nominal_reg, 8'h00,
                    level_reg[sel_reg]};
                `ASRS_REG_IRQ_STAT: rdata_o[`ASRS_IRQ_W-1:0] <= irq_stat_reg;
                `ASRS_REG_IRQ_MASK: rdata_o[`ASRS_IRQ_W-1:0] <= irq_mask_reg;
                default: rdata_o <= 32'h00000000;
            endcase
        end
        else
            rdata_o <= 32'h00000000;
    end
endmodule // asrs_stats

// [verification/asrs_stats_asserts.sv]
// Concurrent checks on the ports of the receive statistics block
`timescale 1ns/1ps
module asrs_stats_chk (
    input wire clk_i, // Clock
    input wire reset_n_i, // Synchronous reset, active low
    input wire pkt_valid_i, // Packet arrival
    input wire rd_valid_i, // DSP read cycle
    input wire [7:0] addr_i, // Register address
    input wire [31:0] wdata_i, // Register write data
    input wire wr_i, // Write strobe
    input wire rd_i, // Read strobe
    input wire [31:0] rdata_o, // Read data
    input wire irq_o // Level interrupt
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // ==========================================================
    // Register port
    chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data not zero outside its slot");
    chk_ctrl_reads_zero: assert property (rd_i && addr_i == 8'h00 |=> rdata_o == 32'h0)
        else $error("control register read not zero");
    chk_unmapped_zero: assert property (rd_i && addr_i > 8'h24 |=> rdata_o == 32'h0)
        else $error("unmapped read not zero");
    // Level stays within the buffer depth while nominal is written no higher than 64
    chk_level_bound: assert property (rd_i && addr_i == 8'h1C |=> rdata_o[7:0] <= 8'h40
        && rdata_o[31:24] == 8'h00 && rdata_o[15:8] == 8'h00)
        else $error("level register out of range");
    // A clear shows as zero at the next quiet counter read
    chk_clear_zero: assert property (wr_i && addr_i == 8'h00 && wdata_i[0]
        ##1 !pkt_valid_i && !rd_valid_i
        ##1 rd_i && addr_i >= 8'h08 && addr_i <= 8'h18 |=> rdata_o == 32'h0)
        else $error("counter not zero after clear");
    // ==========================================================
    // Interrupt
    chk_mask_off: assert property (wr_i && addr_i == 8'h24 && wdata_i[3:0] == 4'h0
        ##1 !(wr_i && addr_i == 8'h24) |=> !irq_o)
        else $error("interrupt high with all sources masked");
    chk_stat_clear: assert property (wr_i && addr_i == 8'h20 && wdata_i[3:0] == 4'hF
        && !pkt_valid_i && !rd_valid_i ##1 !pkt_valid_i && !rd_valid_i |=> !irq_o)
        else $error("interrupt high after status cleared");
    // Interrupt rises one edge after an event, or two after a mask write
    chk_irq_cause: assert property ($rose(irq_o) |-> $past(pkt_valid_i || rd_valid_i)
        || $past(wr_i, 2))
        else $error("interrupt rose without a cause");
endmodule // asrs_stats_chk

bind asrs_stats asrs_stats_chk u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .pkt_valid_i(pkt_valid_i), .rd_valid_i(rd_valid_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));

// [verification/asrs_peer.sv]
// Model of the packet sources and the DSP reader facing the block
`timescale 1ns/1ps
module asrs_peer (
    input wire clk_i, // Clock
    output reg pkt_valid_o = 1'b0, // Packet arrival pulse
    output reg [8:0] pkt_input_o = 9'h0, // Packet input index
    output reg [31:0] pkt_ts_o = 32'h0, // Packet timestamp
    output reg pkt_live_o = 1'b0, // Live packet
    output reg rd_valid_o = 1'b0, // DSP read pulse
    output reg [8:0] rd_input_o = 9'h0 // Input read
);
    // ==========================================================
    // One packet, a single-cycle pulse; released fields go stale-free
    task send(input [8:0] idx, input [31:0] ts, input live);
        begin
            @(posedge clk_i);
            pkt_valid_o <= 1'b1;
            pkt_input_o <= idx;
            pkt_ts_o <= ts;
            pkt_live_o <= live;
            @(posedge clk_i);
            pkt_valid_o <= 1'b0;
            // Inverted leftovers so a late sample of them cannot pass
            pkt_input_o <= ~idx;
            pkt_ts_o <= ~ts;
            pkt_live_o <= ~live;
        end
    endtask
    // One DSP read cycle for one input
    task pull(input [8:0] idx);
        begin
            @(posedge clk_i);
            rd_valid_o <= 1'b1;
            rd_input_o <= idx;
            @(posedge clk_i);
            rd_valid_o <= 1'b0;
            rd_input_o <= ~idx;
        end
    endtask
endmodule // asrs_peer

// [verification/audio_stream_receive_stats_bench.sv]
// Self-checking bench for the receive statistics block
`timescale 1ns/1ps
module audio_stream_receive_stats_bench;
    reg clk_i = 1'b0;
    reg reset_n_i = 1'b0;
    reg [7:0] addr_i = 8'h00;
    reg [31:0] wdata_i = 32'h0;
    reg wr_i = 1'b0;
    reg rd_i = 1'b0;
    wire pkt_valid, pkt_live, rd_valid, irq_o;
    wire [8:0] pkt_input, rd_input;
    wire [31:0] pkt_ts, rdata_o;
    integer fail_count = 0;
    integer comparisons = 0;
    integer i;
    // 20 MHz clock
    always #25 clk_i = ~clk_i;
    asrs_peer peer (.clk_i(clk_i), .pkt_valid_o(pkt_valid), .pkt_input_o(pkt_input),
        .pkt_ts_o(pkt_ts), .pkt_live_o(pkt_live), .rd_valid_o(rd_valid), .rd_input_o(rd_input));
    asrs_stats uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .pkt_valid_i(pkt_valid),
        .pkt_input_i(pkt_input), .pkt_ts_i(pkt_ts), .pkt_live_i(pkt_live),
        .rd_valid_i(rd_valid), .rd_input_i(rd_input), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
    // ==========================================================
    // Shared tasks
    task check(input string name, input [31:0] seen, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp)
            begin
                fail_count = fail_count + 1;
                $display("unexpected %s: expected %h, seen %h", name, exp, seen);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk_i);
            wr_i <= 1'b1;
            addr_i <= a;
            wdata_i <= d;
            @(posedge clk_i);
            wr_i <= 1'b0;
        end
    endtask
    // Read data stand only in the cycle after the strobe
    task rd(input [7:0] a, input [31:0] exp);
        begin
            @(posedge clk_i);
            rd_i <= 1'b1;
            addr_i <= a;
            @(posedge clk_i);
            rd_i <= 1'b0;
            #1;
            check("read data", rdata_o, exp);
        end
    endtask
    task counts(input [7:0] n, input [7:0] o, input [7:0] r, input [7:0] s, input [7:0] u);
        begin
            rd(8'h08, {24'h0, n});
            rd(8'h0C, {24'h0, o});
            rd(8'h10, {24'h0, r});
            rd(8'h14, {24'h0, s});
            rd(8'h18, {24'h0, u});
        end
    endtask
    task summarize;
        begin
            $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
            if (fail_count == 0 && comparisons > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    // Watchdog: the tests need well under a thousand cycles
    initial
    begin
        #2000000;
        fail_count = fail_count + 1;
        summarize;
    end
    // ==========================================================
    // Test sequence
    initial
    begin
        repeat (10) @(posedge clk_i);
        reset_n_i <= 1'b1;
        wr(8'h24, 32'hF);
        wr(8'h04, 32'h3);
        peer.send(9'h3, 32'h64, 1'b1);
        counts(8'h1, 8'h0, 8'h1, 8'h0, 8'h0);
        rd(8'h1C, 32'h0020_0020);
        check("irq", {31'h0, irq_o}, 32'h1);
        $display("test resume done");
        peer.send(9'h3, 32'h70, 1'b1);
        peer.send(9'h3, 32'h94, 1'b1);
        peer.send(9'h3, 32'h88, 1'b1);
        counts(8'h2, 8'h0, 8'h1, 8'h1, 8'h0);
        $display("test sequence done");
        // Nominal at 63 so two packets reach a full buffer
        wr(8'h1C, 32'h3F);
        wr(8'h04, 32'h5);
        for (i = 0; i < 5; i = i + 1)
            peer.send(9'h5, i * 12, 1'b1);
        counts(8'h3, 8'h2, 8'h1, 8'h0, 8'h0);
        rd(8'h1C, 32'h003F_003F);
        wr(8'h04, 32'h3);
        rd(8'h0C, 32'h0);
        $display("test overrun done");
        wr(8'h1C, 32'h1);
        wr(8'h04, 32'h7);
        peer.send(9'h7, 32'h0, 1'b0);
        peer.pull(9'h7);
        peer.pull(9'h7);
        rd(8'h18, 32'h14);
        peer.send(9'h7, 32'h3E8, 1'b1);
        peer.pull(9'h7);
        peer.pull(9'h7);
        counts(8'h2, 8'h0, 8'h2, 8'h0, 8'h15);
        $display("test underrun done");
        rd(8'h20, 32'hF);
        wr(8'h20, 32'hF);
        rd(8'h20, 32'h0);
        check("irq", {31'h0, irq_o}, 32'h0);
        wr(8'h24, 32'h0);
        peer.send(9'h9, 32'h0, 1'b1);
        rd(8'h20, 32'h2);
        check("irq", {31'h0, irq_o}, 32'h0);
        wr(8'h24, 32'h2);
        rd(8'h24, 32'h2);
        check("irq", {31'h0, irq_o}, 32'h1);
        $display("test interrupt done");
        // Highest input index keeps its own counters
        wr(8'h04, 32'h128);
        peer.send(9'h128, 32'h0, 1'b1);
        rd(8'h08, 32'h1);
        wr(8'h00, 32'h1);
        counts(8'h0, 8'h0, 8'h0, 8'h0, 8'h0);
        rd(8'h00, 32'h0);
        rd(8'h40, 32'h0);
        wr(8'h04, 32'h129);
        rd(8'h08, 32'h0);
        $display("test clear done");
        summarize;
    end
endmodule // audio_stream_receive_stats_bench
